// ---- design/fps_pkg.sv ----
// Constants and bus carriers for the flash program/erase controller.
// Assumes the flash module shares the controller clock (20 MHz).
package fps_pkg;

    // ------------------------------------------------------------------
    // Clock and timing (times in microseconds, counts in cycles)
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ               = 20_000_000;
    localparam int unsigned SUPPLY_SETTLE_US     = 10;
    localparam int unsigned PROGRAM_PULSE_MIN_US = 100;
    localparam int unsigned PROGRAM_MARGIN_US    = 1000;
    localparam int unsigned PROGRAM_LIMIT_US     = 10000;
    localparam int unsigned PROGRAM_TURNOFF_US   = 10;
    localparam int unsigned ERASE_PULSE_MIN_US   = 1000;
    localparam int unsigned ERASE_MARGIN_US      = 10000;
    localparam int unsigned ERASE_LIMIT_US       = 100000;
    localparam int unsigned ERASE_TURNOFF_US     = 100;

    // Least times round up to whole cycles
    function automatic int unsigned us_to_cyc(input int unsigned us);
        longint unsigned c;
        c = (64'(us) * 64'(CLK_HZ) + 64'd999_999) / 64'd1_000_000;
        return (c == 0) ? 1 : 32'(c);
    endfunction

    localparam int unsigned SUPPLY_SETTLE_CYC     = us_to_cyc(SUPPLY_SETTLE_US);
    localparam int unsigned PROGRAM_PULSE_MIN_CYC = us_to_cyc(PROGRAM_PULSE_MIN_US);
    localparam int unsigned PROGRAM_MARGIN_CYC    = us_to_cyc(PROGRAM_MARGIN_US);
    localparam int unsigned PROGRAM_LIMIT_CYC     = us_to_cyc(PROGRAM_LIMIT_US);
    localparam int unsigned PROGRAM_TURNOFF_CYC   = us_to_cyc(PROGRAM_TURNOFF_US);
    localparam int unsigned ERASE_PULSE_MIN_CYC   = us_to_cyc(ERASE_PULSE_MIN_US);
    localparam int unsigned ERASE_MARGIN_CYC      = us_to_cyc(ERASE_MARGIN_US);
    localparam int unsigned ERASE_LIMIT_CYC       = us_to_cyc(ERASE_LIMIT_US);
    localparam int unsigned ERASE_TURNOFF_CYC     = us_to_cyc(ERASE_TURNOFF_US);

    // ------------------------------------------------------------------
    // Array geometry and control word layout
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W       = 11;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned SCAN_W       = 10;
    localparam logic [9:0]  SCAN_LAST    = 10'h3FF;
    localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
    localparam logic [15:0] PROGRAMMED   = 16'h0000;
    localparam int unsigned CTL_LATCH    = 0;
    localparam int unsigned CTL_VERIFY   = 1;
    localparam int unsigned CTL_ERASE    = 2;
    localparam int unsigned CTL_APPLY    = 3;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic              ctrl;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fps_req_s;

    typedef struct packed {
        logic              done;
        logic              ok;
        logic              bad;
    } fps_result_s;

    typedef enum logic [13:0] {
        S_IDLE   = 14'h0001,
        S_SUPPLY = 14'h0002,
        S_SETUP  = 14'h0004,
        S_LATCH  = 14'h0008,
        S_HVON   = 14'h0010,
        S_PULSE  = 14'h0020,
        S_HVOFF  = 14'h0040,
        S_RECOV  = 14'h0080,
        S_VERIFY = 14'h0100,
        S_CLEAR  = 14'h0200,
        S_SCAN   = 14'h0400,
        S_DROP   = 14'h0800,
        S_RDBACK = 14'h1000,
        S_FINISH = 14'h2000
    } fps_state_e;

endpackage

// ---- design/fps_sequencer.sv ----
// Host-side controller that programs and erases the flash array through
// the module's control word and array write/read port.
// Assumes the flash port runs on CLK and acknowledges each request once.
//
// Function
// - program mode: erase clear, latch and verify set
// - write target address and data once to latch
// - apply, wait pulse, remove, wait turnoff
// - verify read all zeros means programmed
// - retry with longer pulse until limit reached
// - one margin pulse, then recheck programmed
// - clear verify and latch after each location
// - supply lowered, read back, mismatch marks bad
// - erase starts at minimum pulse, three bits set
// - one arming write, data value ignored
// - erase pulse, remove, wait turnoff before changes
// - clear control bits then scan whole array
// - retry erase with longer pulse until limit
// - one margin erase pass, recheck erased
`timescale 1ns/1ps
module fps_sequencer #(
    parameter int unsigned SUPPLY_CYC     = fps_pkg::SUPPLY_SETTLE_CYC,
    parameter int unsigned PROG_MIN_CYC   = fps_pkg::PROGRAM_PULSE_MIN_CYC,
    parameter int unsigned PROG_MARG_CYC  = fps_pkg::PROGRAM_MARGIN_CYC,
    parameter int unsigned PROG_LIM_CYC   = fps_pkg::PROGRAM_LIMIT_CYC,
    parameter int unsigned PROG_OFF_CYC   = fps_pkg::PROGRAM_TURNOFF_CYC,
    parameter int unsigned ERASE_MIN_CYC  = fps_pkg::ERASE_PULSE_MIN_CYC,
    parameter int unsigned ERASE_MARG_CYC = fps_pkg::ERASE_MARGIN_CYC,
    parameter int unsigned ERASE_LIM_CYC  = fps_pkg::ERASE_LIMIT_CYC,
    parameter int unsigned ERASE_OFF_CYC  = fps_pkg::ERASE_TURNOFF_CYC
) (
    input  wire logic                         CLK,
    input  wire logic                         RST,
    input  wire logic                         CMD_VALID,
    output logic                              CMD_READY,
    input  wire logic                         CMD_ERASE,
    input  wire logic [fps_pkg::ADDR_W-1:0]   CMD_ADDR,
    input  wire logic [fps_pkg::DATA_W-1:0]   CMD_DATA,
    output fps_pkg::fps_result_s              RESULT,
    output logic                              SUPPLY_ON,
    output fps_pkg::fps_req_s                 DEV_REQ,
    input  wire logic                         DEV_ACK,
    input  wire logic [fps_pkg::DATA_W-1:0]   DEV_RDATA
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Control word from its four bits
    function automatic logic [15:0] ctl_word(input logic lat, input logic ver,
                                             input logic ers, input logic app);
        logic [15:0] w;
        w = 16'h0000;
        w[fps_pkg::CTL_LATCH]  = lat;
        w[fps_pkg::CTL_VERIFY] = ver;
        w[fps_pkg::CTL_ERASE]  = ers;
        w[fps_pkg::CTL_APPLY]  = app;
        return w;
    endfunction

    fps_pkg::fps_state_e state_q;
    fps_pkg::fps_req_s   req_q;
    fps_pkg::fps_req_s   want;
    fps_pkg::fps_result_s res_q;
    logic                bus_state;
    logic                issued_q;
    logic                bus_done;
    logic [31:0]         cnt_q;
    logic [31:0]         pulse_q;
    logic [31:0]         total_q;
    logic [31:0]         limit;
    logic                margin_q;
    logic                erase_q;
    logic                fail_q;
    logic                bad_q;
    logic [fps_pkg::ADDR_W-1:0] addr_q;
    logic [fps_pkg::DATA_W-1:0] data_q;
    logic [fps_pkg::SCAN_W-1:0] scan_q;
    logic                verified;
    logic                over;
    logic                scan_fail;

    assign bus_done  = issued_q & DEV_ACK;
    assign limit     = erase_q ? 32'(ERASE_LIM_CYC) : 32'(PROG_LIM_CYC);
    assign over      = total_q >= limit;
    assign verified  = DEV_RDATA == fps_pkg::PROGRAMMED;
    assign scan_fail = fail_q | (DEV_RDATA != fps_pkg::ERASED_WORD);
    assign CMD_READY = state_q == fps_pkg::S_IDLE;
    assign DEV_REQ   = req_q;
    assign RESULT    = res_q;

    // ------------------------------------------------------------------
    // Access wanted by each bus state
    // ------------------------------------------------------------------
    always_comb begin
        want      = '0;
        bus_state = 1'b1;
        unique case (state_q)
            fps_pkg::S_SETUP: begin
                want.wr    = 1'b1;
                want.ctrl  = 1'b1;
                want.wdata = ctl_word(1'b1, 1'b1, erase_q, 1'b0);
            end
            fps_pkg::S_LATCH: begin
                want.wr    = 1'b1;
                want.addr  = addr_q;
                want.wdata = erase_q ? 16'h0000 : data_q;
            end
            fps_pkg::S_HVON: begin
                want.wr    = 1'b1;
                want.ctrl  = 1'b1;
                want.wdata = ctl_word(1'b1, 1'b1, erase_q, 1'b1);
            end
            fps_pkg::S_HVOFF: begin
                want.wr    = 1'b1;
                want.ctrl  = 1'b1;
                want.wdata = ctl_word(1'b1, 1'b1, erase_q, 1'b0);
            end
            fps_pkg::S_VERIFY: begin
                want.rd    = 1'b1;
                want.addr  = addr_q;
            end
            fps_pkg::S_CLEAR: begin
                want.wr    = 1'b1;
                want.ctrl  = 1'b1;
                want.wdata = ctl_word(1'b0, 1'b0, 1'b0, 1'b0);
            end
            fps_pkg::S_SCAN: begin
                want.rd    = 1'b1;
                want.addr  = {scan_q, 1'b0};
            end
            fps_pkg::S_RDBACK: begin
                want.rd    = 1'b1;
                want.addr  = addr_q;
            end
            default: bus_state = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Request strobe, held until acknowledged
    // ------------------------------------------------------------------
    // Request drops for one cycle between accesses so each is distinct
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            req_q    <= '0;
            issued_q <= 1'b0;
        end else if (bus_done) begin
            req_q    <= '0;
            issued_q <= 1'b0;
        end else if (bus_state && !issued_q) begin
            req_q    <= want;
            issued_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= fps_pkg::S_IDLE;
        end else begin
            unique case (state_q)
                fps_pkg::S_IDLE:   if (CMD_VALID) state_q <= fps_pkg::S_SUPPLY;
                fps_pkg::S_SUPPLY: if (cnt_q == 0) state_q <= fps_pkg::S_SETUP;
                fps_pkg::S_SETUP:  if (bus_done) state_q <= fps_pkg::S_LATCH;
                fps_pkg::S_LATCH:  if (bus_done) state_q <= fps_pkg::S_HVON;
                fps_pkg::S_HVON:   if (bus_done) state_q <= fps_pkg::S_PULSE;
                fps_pkg::S_PULSE:  if (cnt_q == 0) state_q <= fps_pkg::S_HVOFF;
                fps_pkg::S_HVOFF:  if (bus_done) state_q <= fps_pkg::S_RECOV;
                fps_pkg::S_RECOV: begin
                    if (cnt_q == 0) begin
                        state_q <= erase_q ? fps_pkg::S_CLEAR : fps_pkg::S_VERIFY;
                    end
                end
                fps_pkg::S_VERIFY: begin
                    if (bus_done) begin
                        if (verified ? margin_q : (margin_q || over)) begin
                            state_q <= fps_pkg::S_CLEAR;
                        end else begin
                            state_q <= fps_pkg::S_HVON;
                        end
                    end
                end
                fps_pkg::S_CLEAR: begin
                    if (bus_done) begin
                        state_q <= erase_q ? fps_pkg::S_SCAN : fps_pkg::S_DROP;
                    end
                end
                fps_pkg::S_SCAN: begin
                    if (bus_done && scan_q == fps_pkg::SCAN_LAST) begin
                        if (scan_fail ? (margin_q || over) : margin_q) begin
                            state_q <= fps_pkg::S_DROP;
                        end else begin
                            state_q <= fps_pkg::S_SETUP;
                        end
                    end
                end
                fps_pkg::S_DROP: begin
                    if (cnt_q == 0) begin
                        state_q <= (erase_q || bad_q) ? fps_pkg::S_FINISH : fps_pkg::S_RDBACK;
                    end
                end
                fps_pkg::S_RDBACK: if (bus_done) state_q <= fps_pkg::S_FINISH;
                fps_pkg::S_FINISH: state_q <= fps_pkg::S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Wait counter, loaded as each timed wait begins
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= 32'h00000000;
        end else if (state_q == fps_pkg::S_IDLE) begin
            cnt_q <= 32'(SUPPLY_CYC) - 32'h1;
        end else if (state_q == fps_pkg::S_HVON && bus_done) begin
            cnt_q <= pulse_q - 32'h1;
        end else if (state_q == fps_pkg::S_HVOFF && bus_done) begin
            cnt_q <= (erase_q ? 32'(ERASE_OFF_CYC) : 32'(PROG_OFF_CYC)) - 32'h1;
        end else if (state_q == fps_pkg::S_CLEAR || state_q == fps_pkg::S_SCAN) begin
            cnt_q <= 32'(SUPPLY_CYC) - 32'h1;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Pulse width, cumulative time and margin tracking
    // ------------------------------------------------------------------
    // Retry doubles the pulse; margin pulse time is not counted toward the limit
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pulse_q  <= 32'h00000000;
            total_q  <= 32'h00000000;
            margin_q <= 1'b0;
            bad_q    <= 1'b0;
            fail_q   <= 1'b0;
        end else if (state_q == fps_pkg::S_IDLE) begin
            pulse_q  <= CMD_ERASE ? 32'(ERASE_MIN_CYC) : 32'(PROG_MIN_CYC);
            total_q  <= 32'h00000000;
            margin_q <= 1'b0;
            bad_q    <= 1'b0;
            fail_q   <= 1'b0;
        end else if (state_q == fps_pkg::S_HVON && bus_done && !margin_q) begin
            total_q <= total_q + pulse_q;
        end else if (state_q == fps_pkg::S_VERIFY && bus_done) begin
            if (verified && !margin_q) begin
                margin_q <= 1'b1;
                pulse_q  <= 32'(PROG_MARG_CYC);
            end else if (!verified) begin
                bad_q   <= margin_q | over;
                pulse_q <= {pulse_q[30:0], 1'b0};
            end
        end else if (state_q == fps_pkg::S_SCAN && bus_done) begin
            fail_q <= scan_fail;
            if (scan_q == fps_pkg::SCAN_LAST) begin
                fail_q <= 1'b0;
                if (!scan_fail && !margin_q) begin
                    margin_q <= 1'b1;
                    pulse_q  <= 32'(ERASE_MARG_CYC);
                end else if (scan_fail) begin
                    bad_q   <= margin_q | over;
                    pulse_q <= {pulse_q[30:0], 1'b0};
                end
            end
        end else if (state_q == fps_pkg::S_RDBACK && bus_done) begin
            bad_q <= DEV_RDATA != data_q;
        end
    end

    // ------------------------------------------------------------------
    // Command capture and scan address
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            erase_q <= 1'b0;
            addr_q  <= '0;
            data_q  <= '0;
            scan_q  <= '0;
        end else begin
            if (state_q == fps_pkg::S_IDLE && CMD_VALID) begin
                erase_q <= CMD_ERASE;
                addr_q  <= CMD_ADDR;
                data_q  <= CMD_DATA;
            end
            if (state_q == fps_pkg::S_SCAN && bus_done) begin
                scan_q <= scan_q + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Supply pin and result
    // ------------------------------------------------------------------
    // Supply stays up across retries; dropped before the final read back
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SUPPLY_ON <= 1'b0;
            res_q     <= '0;
        end else begin
            if (state_q == fps_pkg::S_IDLE && CMD_VALID) begin
                SUPPLY_ON <= 1'b1;
                res_q     <= '0;
            end else if (state_q == fps_pkg::S_DROP) begin
                SUPPLY_ON <= 1'b0;
            end
            res_q.done <= state_q == fps_pkg::S_FINISH;
            if (state_q == fps_pkg::S_FINISH) begin
                res_q.ok  <= !bad_q;
                res_q.bad <= bad_q;
            end
        end
    end

endmodule

// ---- verification/flash_program_erase_sequencer_tb.sv ----
// Self-checking bench: controller against a behavioural flash module.
// Assumes short simulation timings handed to the controller parameters.
`timescale 1ns/1ps
module flash_program_erase_sequencer_tb;
    // ------------------------------------------------------------------
    // Signals, reference array and helpers
    // ------------------------------------------------------------------
    logic                 clk, rst, cmd_valid, cmd_erase, cmd_ready, supply_on, dev_ack;
    logic [10:0]          cmd_addr;
    logic [15:0]          cmd_data, dev_rdata, need;
    logic [1:0]           ack_dly = 2'h0;
    logic [31:0]          lfsr_q = 32'hB5F9C0DD;
    logic [15:0]          mem_m [1024];
    fps_pkg::fps_result_s result;
    fps_pkg::fps_req_s    dev_req;
    int                   failures, checked;

    // Supply, turn-off and program limit keep their defaults; program never reaches its limit
    fps_sequencer #(.PROG_MIN_CYC(4), .PROG_MARG_CYC(8), .ERASE_MIN_CYC(4), .ERASE_MARG_CYC(8),
        .ERASE_LIM_CYC(40)) u_dut (.CLK(clk), .RST(rst), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_ERASE(cmd_erase), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
        .RESULT(result), .SUPPLY_ON(supply_on), .DEV_REQ(dev_req), .DEV_ACK(dev_ack),
        .DEV_RDATA(dev_rdata));
    fps_flash_model u_dev (.clk(clk), .rst(rst), .req(dev_req), .ack_dly(ack_dly), .need(need),
        .ack(dev_ack), .rdata(dev_rdata));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Free-running random source also varies the answer delay
    always @(posedge clk) begin
        lfsr_q <= lfsr_next(lfsr_q);
        ack_dly <= lfsr_q[1:0];
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One command; the reference decides the outcome before the run ends
    task automatic run_cmd(input logic ers, input logic [10:0] a, input logic [15:0] d,
                           input logic [15:0] nd);
        logic ok;
        int   n;
        ok = ers ? (nd < 16'd50) : ((mem_m[a[10:1]] & d) == d);
        if (ok && ers) foreach (mem_m[i]) mem_m[i] = 16'hFFFF;
        if (!ers) mem_m[a[10:1]] = mem_m[a[10:1]] & d;
        @(posedge clk);
        need <= nd;
        cmd_valid <= 1'b1;
        cmd_erase <= ers;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1 check({14'h0000, supply_on, cmd_ready}, 16'h0002, "busy after accept");
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_addr <= ~a;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 60000 && result.done !== 1'b1; n++) @(posedge clk) #1;
        if (n >= 60000) begin
            failures++;
            print_verdict();
        end
        check({13'h0000, supply_on, result.ok, result.bad}, {13'h0000, 1'b0, ok, !ok},
              "result");
        repeat (3) @(posedge clk) #1 check({15'h0000, cmd_ready}, 16'h0001, "idle");
        check({14'h0000, result.ok, result.bad}, {14'h0000, ok, !ok}, "held");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [10:0] a;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_erase = 1'b0;
        cmd_addr = 11'h000;
        cmd_data = 16'h0000;
        need = 16'h0001;
        failures = 0;
        checked = 0;
        foreach (mem_m[i]) mem_m[i] = 16'h0000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        run_cmd(1'b1, 11'h00E, lfsr_q[15:0], 16'h0001);
        repeat (4) begin
            a = {lfsr_q[9:0], 1'b0};
            run_cmd(1'b0, a, lfsr_q[31:16], 16'h0001);
            run_cmd(1'b0, a, lfsr_q[25:10], 16'h0001);
        end
        run_cmd(1'b0, 11'h7FE, 16'h0F0F, 16'd10);
        run_cmd(1'b0, 11'h010, 16'h00FF, 16'd5000);
        run_cmd(1'b1, 11'h002, 16'hA5A5, 16'd5000);
        run_cmd(1'b1, 11'h00E, 16'h5A5A, 16'h0001);
        run_cmd(1'b0, 11'h010, 16'h0000, 16'h0001);
        print_verdict();
    end
endmodule

// ---- verification/fps_flash_model.sv ----
// Behavioural flash module with control word, latches and array.
// Assumes one request at a time from the controller on the same clock.
`timescale 1ns/1ps
module fps_flash_model (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire fps_pkg::fps_req_s req,
    input  wire logic [1:0]        ack_dly,
    input  wire logic [15:0]       need,
    output logic                   ack,
    output logic [15:0]            rdata
);
    // ------------------------------------------------------------------
    // Control word, latches and array
    // ------------------------------------------------------------------
    logic [15:0] mem [1024];
    logic [3:0]  ctl_q;
    logic        latched_q;
    logic [9:0]  la_q;
    logic [15:0] ld_q;
    logic [15:0] acc_q;
    logic [1:0]  wait_q;

    // Slow or prompt answer; released data line toggles so no stale value survives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            rdata <= 16'h0000;
            ctl_q <= 4'h0;
            latched_q <= 1'b0;
            la_q <= 10'h000;
            ld_q <= 16'h0000;
            acc_q <= 16'h0000;
            wait_q <= 2'h0;
            for (int i = 0; i < 1024; i++) mem[i] <= 16'h0000;
        end else begin
            rdata <= ~rdata;
            ack <= 1'b0;
            // Pulse time builds up only while voltage is applied; software times it
            if (ctl_q[3]) begin
                acc_q <= acc_q + 16'h0001;
                if (acc_q + 16'h0001 >= need) begin
                    if (ctl_q[2]) begin
                        for (int i = 0; i < 1024; i++) mem[i] <= 16'hFFFF;
                    end else begin
                        mem[la_q] <= mem[la_q] & ld_q;
                    end
                end
            end
            if (!ack && (req.rd || req.wr)) begin
                wait_q <= wait_q + 2'h1;
                if (wait_q >= ack_dly) begin
                    ack <= 1'b1;
                    wait_q <= 2'h0;
                    if (req.wr && req.ctrl) begin
                        // Mode bits frozen under voltage; apply needs a latching write
                        if (!ctl_q[3]) ctl_q[2:0] <= req.wdata[2:0];
                        ctl_q[3] <= req.wdata[3] & (ctl_q[3] | (req.wdata[0] & latched_q));
                        if (!req.wdata[0] && !ctl_q[3]) latched_q <= 1'b0;
                    end else if (req.wr && ctl_q[0] && !ctl_q[3]) begin
                        latched_q <= 1'b1;
                        la_q <= req.addr[10:1];
                        ld_q <= req.wdata;
                        acc_q <= 16'h0000;
                    end else if (req.rd && ctl_q[3]) begin
                        rdata <= ~rdata;
                    end else if (req.rd && ctl_q[0] && !ctl_q[2]) begin
                        rdata <= mem[la_q] & ~ld_q;
                    end else if (req.rd) begin
                        rdata <= mem[req.addr[10:1]];
                    end
                end
            end
        end
    end
endmodule

// ---- verification/fps_sequencer_checker.sv ----
// Port-level assertions for the program/erase controller.
// Assumes it is bound into every instance of the controller.
`timescale 1ns/1ps
module fps_sequencer_checker (
    input wire logic                       CLK,
    input wire logic                       RST,
    input wire logic                       CMD_VALID,
    input wire logic                       CMD_READY,
    input wire fps_pkg::fps_result_s       RESULT,
    input wire logic                       SUPPLY_ON,
    input wire fps_pkg::fps_req_s          DEV_REQ,
    input wire logic                       DEV_ACK
);
    // ------------------------------------------------------------------
    // Shadow of the control word as the controller has written it
    // ------------------------------------------------------------------
    logic [3:0] bits_q;
    logic       latched_q;

    // Tracks accepted writes only, since an unanswered request changes nothing
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bits_q <= 4'h0;
            latched_q <= 1'b0;
        end else if (DEV_ACK && DEV_REQ.wr) begin
            if (DEV_REQ.ctrl) begin
                bits_q <= DEV_REQ.wdata[3:0];
                if (!DEV_REQ.wdata[0]) latched_q <= 1'b0;
            end else if (bits_q[0]) begin
                latched_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    accept_busy_a: assert property (CMD_VALID && CMD_READY |=> !CMD_READY && SUPPLY_ON)
        else $error("command accept did not start a run");
    req_hold_a: assert property ((DEV_REQ.rd || DEV_REQ.wr) && !DEV_ACK |=> $stable(DEV_REQ))
        else $error("flash request changed before answer");
    req_gap_a: assert property (DEV_ACK |=> !DEV_REQ.rd && !DEV_REQ.wr)
        else $error("no idle cycle after answer");
    mode_setup_a: assert property (DEV_REQ.wr && DEV_REQ.ctrl && DEV_REQ.wdata[0] |-> DEV_REQ.wdata[1] && DEV_REQ.addr == 11'h000 && DEV_REQ.wdata[15:4] == 12'h000)
        else $error("latch set without verify or bad control word");
    apply_latch_a: assert property (DEV_REQ.wr && DEV_REQ.ctrl && DEV_REQ.wdata[3] |-> latched_q && DEV_REQ.wdata[0])
        else $error("apply requested before a latching write");
    frozen_mode_a: assert property (DEV_REQ.wr && DEV_REQ.ctrl && bits_q[3] |-> DEV_REQ.wdata[2:0] == bits_q[2:0])
        else $error("mode bits changed under voltage");
    read_apply_a: assert property (DEV_REQ.rd |-> !bits_q[3] && !DEV_REQ.wr)
        else $error("array read while voltage applied");
    arm_data_a: assert property (DEV_REQ.wr && !DEV_REQ.ctrl && bits_q[2] |-> DEV_REQ.wdata == 16'h0000)
        else $error("arming write carries data");
    done_pulse_a: assert property (RESULT.done |-> !SUPPLY_ON && (RESULT.ok != RESULT.bad) ##1 !RESULT.done && CMD_READY)
        else $error("result pulse malformed");
    result_hold_a: assert property (!(CMD_VALID && CMD_READY) ##1 !RESULT.done |-> $stable({RESULT.ok, RESULT.bad}))
        else $error("result level changed without a command");
endmodule

bind fps_sequencer fps_sequencer_checker u_chk (
    .CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .RESULT(RESULT),
    .SUPPLY_ON(SUPPLY_ON), .DEV_REQ(DEV_REQ), .DEV_ACK(DEV_ACK)
);
